// File: design/lcd_panel_timing.sv
// Purpose: Video timing generator driving an 800x480 parallel RGB panel.
// Assumes: pix_clk runs free from an external source inside the panel's range.
// Notes: Software sets timing over APB; changes take effect at a frame boundary while running, or at once while stopped.
// How it works
// - Colour leaves as 24 bits, eight per channel, one pixel per pixel clock.
// - Colour, valid qualifier and syncs come from one counter set, so stay aligned.
// - Pixel clock source must run 26.4 to 46.8 MHz, nominally 33.3 MHz.
// - Every line carries exactly 800 active pixel clocks.
// - Line total is 46 + 800 + front porch, so 862 to 1200 clocks.
// - Horizontal sync width is clamped to 1 through 40 clocks.
// - Horizontal blanking before active pixels is fixed at 46 clocks.
// - Horizontal front porch is clamped to 16 through 354 clocks.
// - Every frame carries exactly 480 active lines.
// - Vertical sync width is clamped to 1 through 20 lines.
// - Vertical blanking before the first active line is fixed at 23 lines.
// - Vertical front porch is clamped to 7 through 147 lines.
// - A control bit drives the panel backlight enable.
// - A control bit holds the panel's timing mode select steady.
// - A horizontal sync output goes to the panel.
`timescale 1ns/10ps
module lcd_panel_timing (
  input wire logic mclk,
  input wire logic rst_b,
  input wire lcd_timing_pkg::apb_req_type apb_req,
  output lcd_timing_pkg::apb_rsp_type apb_rsp,
  input wire logic pix_clk,
  output logic pixel_clock,
  output logic pixel_valid,
  output logic hsync_in_b,
  output logic vsync_in_b,
  output lcd_timing_pkg::rgb_type pixel_rgb,
  output logic backlight_on,
  output logic sync_select
);
  import lcd_timing_pkg::*;

  // ---------------- Control domain (mclk) ----------------
  logic en_q;
  pattern_type pat_q;
  rgb_type colour_q;
  logic [5:0] hpw_q;
  logic [8:0] hfp_q;
  logic [4:0] vpw_q;
  logic [7:0] vfp_q;
  logic dirty_q;
  logic dirty_d;
  logic [15:0] frame_cnt_q;
  logic frm_meta_q;
  logic frm_sync_q;
  logic frm_seen_q;
  logic run_meta_q;
  logic run_sync_q;
  logic cfg_busy;
  logic launch;
  logic access;
  logic mapped;
  logic wr_fire;
  logic wr_cfg;
  logic [31:0] rd_data;
  cfg_type cfg_src;

  // ---------------- Pixel domain (pix_clk) ----------------
  logic prst_meta_q;
  logic prst_b_q;
  logic cfg_new;
  cfg_type cfg_rx;
  cfg_type cfg_pend_q;
  cfg_type cfg_act_q;
  logic pend_q;
  logic [10:0] h_q;
  logic [9:0] v_q;
  logic [10:0] line_last;
  logic [9:0] frame_last;
  logic line_end;
  logic frame_wrap;
  logic apply;
  logic frame_tgl_q;
  logic h_active;
  logic v_active;
  logic [9:0] col;
  logic [8:0] row;
  rgb_type pat_rgb;

  // The panel is clocked by the same source that runs the pixel logic
  assign pixel_clock = pix_clk;

  // APB slave: one wait state, pready from a flop
  assign access = apb_req.psel && apb_req.penable;
  assign mapped = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr <= OFS_STATUS);
  assign wr_fire = access && apb_rsp.pready && apb_req.pwrite && mapped;
  assign wr_cfg = wr_fire && (apb_req.paddr != OFS_STATUS);

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (apb_req.paddr)
      OFS_CTRL: begin
        rd_data[CTRL_EN_POS] = en_q;
        rd_data[CTRL_BL_POS] = backlight_on;
        rd_data[CTRL_SEL_POS] = sync_select;
        rd_data[CTRL_PAT_POS +: 2] = pat_q;
      end
      OFS_HTIME: begin
        rd_data[HPW_POS +: 6] = hpw_q;
        rd_data[HFP_POS +: 9] = hfp_q;
      end
      OFS_VTIME: begin
        rd_data[VPW_POS +: 5] = vpw_q;
        rd_data[VFP_POS +: 8] = vfp_q;
      end
      OFS_COLOUR: begin
        rd_data[23:0] = colour_q;
      end
      OFS_STATUS: begin
        rd_data[ST_RUN_POS] = run_sync_q;
        rd_data[ST_PEND_POS] = dirty_q || cfg_busy;
        rd_data[ST_FRAME_POS +: 16] = frame_cnt_q;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Answer one cycle after the first access cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      apb_rsp <= '0;
    end else if (access && !apb_rsp.pready) begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= !mapped;
      apb_rsp.prdata <= (mapped && !apb_req.pwrite) ? rd_data : 32'h0000_0000;
    end else begin
      apb_rsp <= '0;
    end
  end

  // Register writes, timing fields clamped to the panel limits
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      en_q <= 1'b0;
      backlight_on <= 1'b0;
      sync_select <= 1'b0;
      pat_q <= PAT_SOLID;
      colour_q <= COLOUR_RESET;
      hpw_q <= HPW_RESET;
      hfp_q <= HFP_RESET;
      vpw_q <= VPW_RESET;
      vfp_q <= VFP_RESET;
    end else if (wr_fire) begin
      unique case (apb_req.paddr)
        OFS_CTRL: begin
          en_q <= apb_req.pwdata[CTRL_EN_POS];
          backlight_on <= apb_req.pwdata[CTRL_BL_POS];
          sync_select <= apb_req.pwdata[CTRL_SEL_POS];
          pat_q <= pattern_type'(apb_req.pwdata[CTRL_PAT_POS +: 2]);
        end
        OFS_HTIME: begin
          hpw_q <= 6'(clamp10(10'(apb_req.pwdata[HPW_POS +: 6]), 10'(HPW_MIN),
                              10'(HPW_MAX)));
          hfp_q <= 9'(clamp10(10'(apb_req.pwdata[HFP_POS +: 9]), 10'(HFP_MIN),
                              10'(HFP_MAX)));
        end
        OFS_VTIME: begin
          vpw_q <= 5'(clamp10(10'(apb_req.pwdata[VPW_POS +: 5]), 10'(VPW_MIN),
                              10'(VPW_MAX)));
          vfp_q <= 8'(clamp10(10'(apb_req.pwdata[VFP_POS +: 8]), 10'(VFP_MIN),
                              10'(VFP_MAX)));
        end
        OFS_COLOUR: begin
          colour_q <= apb_req.pwdata[23:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Pending change: a write in the launch cycle keeps it pending
  assign launch = dirty_q && !cfg_busy;
  assign dirty_d = (dirty_q && !launch) || wr_cfg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dirty_q <= 1'b0;
    end else begin
      dirty_q <= dirty_d;
    end
  end

  always_comb begin
    cfg_src.enable = en_q;
    cfg_src.pattern = pat_q;
    cfg_src.colour = colour_q;
    cfg_src.hpw = hpw_q;
    cfg_src.hfp = hfp_q;
    cfg_src.vpw = vpw_q;
    cfg_src.vfp = vfp_q;
  end

  word_handshake #(
    .WIDTH(CFG_W)
  ) cfg_xfer (
    .src_clk(mclk),
    .src_rst_b(rst_b),
    .src_load(launch),
    .src_data(cfg_src),
    .src_busy(cfg_busy),
    .dst_clk(pix_clk),
    .dst_rst_b(prst_b_q),
    .dst_valid(cfg_new),
    .dst_data(cfg_rx)
  );

  // Frame toggle and running level back into mclk
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frm_meta_q <= 1'b0;
      frm_sync_q <= 1'b0;
      frm_seen_q <= 1'b0;
      run_meta_q <= 1'b0;
      run_sync_q <= 1'b0;
    end else begin
      frm_meta_q <= frame_tgl_q;
      frm_sync_q <= frm_meta_q;
      frm_seen_q <= frm_sync_q;
      run_meta_q <= cfg_act_q.enable;
      run_sync_q <= run_meta_q;
    end
  end

  // Frame counter wraps at 16 bits
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      frame_cnt_q <= 16'h0000;
    end else if (frm_sync_q != frm_seen_q) begin
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  // Reset brought into the pixel domain
  always_ff @(posedge pix_clk) begin
    prst_meta_q <= rst_b;
    prst_b_q <= prst_meta_q;
  end

  // Line starts with sync, then blanking, then active pixels, then porch
  assign line_last = 11'(H_BLANK + H_ACTIVE + 11'(cfg_act_q.hfp) - 11'd1);
  assign frame_last = 10'(V_BLANK + V_ACTIVE + 10'(cfg_act_q.vfp) - 10'd1);
  assign line_end = h_q == line_last;
  assign frame_wrap = line_end && (v_q == frame_last);
  assign apply = pend_q && (frame_wrap || !cfg_act_q.enable);

  // Newest word wins; its arrival beats the apply clear
  always_ff @(posedge pix_clk) begin
    if (!prst_b_q) begin
      pend_q <= 1'b0;
      cfg_pend_q <= '0;
    end else if (cfg_new) begin
      pend_q <= 1'b1;
      cfg_pend_q <= cfg_rx;
    end else if (apply) begin
      pend_q <= 1'b0;
    end
  end

  // Timing in force, swapped only at an apply
  always_ff @(posedge pix_clk) begin
    if (!prst_b_q) begin
      cfg_act_q <= '{enable: 1'b0, pattern: PAT_SOLID, colour: COLOUR_RESET, hpw: HPW_RESET,
                     hfp: HFP_RESET, vpw: VPW_RESET, vfp: VFP_RESET};
    end else if (apply) begin
      cfg_act_q <= cfg_pend_q;
    end
  end

  // Counters restart at every apply, so new timing starts on a clean line
  always_ff @(posedge pix_clk) begin
    if (!prst_b_q || !cfg_act_q.enable || apply) begin
      h_q <= 11'd0;
      v_q <= 10'd0;
    end else if (line_end) begin
      h_q <= 11'd0;
      v_q <= frame_wrap ? 10'd0 : v_q + 10'd1;
    end else begin
      h_q <= h_q + 11'd1;
    end
  end

  // One toggle per finished frame, counted in the control domain
  always_ff @(posedge pix_clk) begin
    if (!prst_b_q) begin
      frame_tgl_q <= 1'b0;
    end else if (frame_wrap && cfg_act_q.enable) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Active window
  assign h_active = (h_q >= H_BLANK) && (h_q < H_BLANK + H_ACTIVE);
  assign v_active = (v_q >= V_BLANK) && (v_q < V_BLANK + V_ACTIVE);
  assign col = 10'(h_q - H_BLANK);
  assign row = 9'(v_q - V_BLANK);

  // Test patterns
  always_comb begin
    pat_rgb = cfg_act_q.colour;
    unique case (cfg_act_q.pattern)
      PAT_SOLID: begin
        pat_rgb = cfg_act_q.colour;
      end
      PAT_BARS: begin
        pat_rgb.red = {8{col[9]}};
        pat_rgb.green = {8{col[8]}};
        pat_rgb.blue = {8{col[7]}};
      end
      PAT_GRAD: begin
        pat_rgb.red = col[9:2];
        pat_rgb.green = row[8:1];
        pat_rgb.blue = cfg_act_q.colour.blue;
      end
      PAT_INV: begin
        pat_rgb = ~cfg_act_q.colour;
      end
    endcase
  end

  // Panel outputs, all from one counter pair and one register stage
  always_ff @(posedge pix_clk) begin
    if (!prst_b_q) begin
      hsync_in_b <= 1'b1;
      vsync_in_b <= 1'b1;
      pixel_valid <= 1'b0;
      pixel_rgb <= '0;
    end else begin
      hsync_in_b <= !(cfg_act_q.enable && (h_q < 11'(cfg_act_q.hpw)));
      vsync_in_b <= !(cfg_act_q.enable && (v_q < 10'(cfg_act_q.vpw)));
      pixel_valid <= cfg_act_q.enable && h_active && v_active;
      pixel_rgb <= (cfg_act_q.enable && h_active && v_active) ? pat_rgb : '0;
    end
  end

endmodule

// File: design/word_handshake.sv
// Purpose: Carries one word from the source clock domain to the destination domain.
// Assumes: Source waits for busy low before loading the next word.
// Notes: Toggle request and acknowledge, each passing two flip-flops.
`timescale 1ns/10ps
module word_handshake #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_b,
  input wire logic src_load,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  input wire logic dst_rst_b,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data
);

  logic [WIDTH-1:0] hold_q;
  logic req_q;
  logic ack_meta_q;
  logic ack_sync_q;
  logic req_meta_q;
  logic req_sync_q;
  logic req_seen_q;
  logic ack_q;

  // Source side: hold the word, flip the request
  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      hold_q <= '0;
      req_q <= 1'b0;
    end else if (src_load && !src_busy) begin
      hold_q <= src_data;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= ack_q;
      ack_sync_q <= ack_meta_q;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_b) begin
      src_busy <= 1'b0;
    end else begin
      src_busy <= (src_load && !src_busy) ? 1'b1 : (req_q != ack_sync_q);
    end
  end

  // Destination side: take the word when the request flips
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_meta_q <= req_q;
      req_sync_q <= req_meta_q;
      req_seen_q <= req_sync_q;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_b) begin
      dst_valid <= 1'b0;
      dst_data <= '0;
      ack_q <= 1'b0;
    end else begin
      dst_valid <= req_sync_q != req_seen_q;
      if (req_sync_q != req_seen_q) begin
        dst_data <= hold_q;
        ack_q <= req_sync_q;
      end
    end
  end

endmodule

// File: include/lcd_timing_pkg.sv
// Purpose: Constants and carrier types for the panel video timing controller.
// Assumes: APB with 32-bit data; pixel clock comes from an external clock source.
// Notes: Field positions, offsets and reset values live here, except the colour field (bits 23:0) and the enable, backlight and select resets.
package lcd_timing_pkg;

  // Panel geometry and timing, in pixel clocks or line periods
  localparam logic [10:0] H_ACTIVE = 11'd800;
  localparam logic [10:0] H_BLANK = 11'd46;
  localparam logic [10:0] H_LINE_MIN = 11'd862;
  localparam logic [10:0] H_LINE_MAX = 11'd1200;
  localparam logic [5:0] HPW_MIN = 6'd1;
  localparam logic [5:0] HPW_MAX = 6'd40;
  localparam logic [5:0] HPW_RESET = 6'd10;
  localparam logic [8:0] HFP_MIN = 9'd16;
  localparam logic [8:0] HFP_MAX = 9'd354;
  localparam logic [8:0] HFP_RESET = 9'd210;
  localparam logic [9:0] V_ACTIVE = 10'd480;
  localparam logic [9:0] V_BLANK = 10'd23;
  localparam logic [9:0] V_FRAME_MIN = 10'd510;
  localparam logic [9:0] V_FRAME_MAX = 10'd650;
  localparam logic [4:0] VPW_MIN = 5'd1;
  localparam logic [4:0] VPW_MAX = 5'd20;
  localparam logic [4:0] VPW_RESET = 5'd3;
  localparam logic [7:0] VFP_MIN = 8'd7;
  localparam logic [7:0] VFP_MAX = 8'd147;
  localparam logic [7:0] VFP_RESET = 8'd22;

  // Pixel clock range the external source must respect, in kHz
  localparam int unsigned PCLK_MIN_KHZ = 26400;
  localparam int unsigned PCLK_NOM_KHZ = 33300;
  localparam int unsigned PCLK_MAX_KHZ = 46800;

  // Register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HTIME = 8'h04;
  localparam logic [7:0] OFS_VTIME = 8'h08;
  localparam logic [7:0] OFS_COLOUR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Field positions
  localparam int unsigned CTRL_EN_POS = 0;
  localparam int unsigned CTRL_BL_POS = 1;
  localparam int unsigned CTRL_SEL_POS = 2;
  localparam int unsigned CTRL_PAT_POS = 4;
  localparam int unsigned HPW_POS = 0;
  localparam int unsigned HFP_POS = 16;
  localparam int unsigned VPW_POS = 0;
  localparam int unsigned VFP_POS = 16;
  localparam int unsigned ST_RUN_POS = 0;
  localparam int unsigned ST_PEND_POS = 1;
  localparam int unsigned ST_FRAME_POS = 16;

  localparam logic [23:0] COLOUR_RESET = 24'h000000;

  typedef enum logic [1:0] {
    PAT_SOLID = 2'b00,
    PAT_BARS = 2'b01,
    PAT_GRAD = 2'b10,
    PAT_INV = 2'b11
  } pattern_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } rgb_type;

  typedef struct packed {
    logic enable;
    pattern_type pattern;
    rgb_type colour;
    logic [5:0] hpw;
    logic [8:0] hfp;
    logic [4:0] vpw;
    logic [7:0] vfp;
  } cfg_type;

  localparam int unsigned CFG_W = $bits(cfg_type);

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

endpackage

// File: verification/lcd_timing_checker.sv
// Purpose: Port assertions for the panel timing controller.
// Assumes: pix_clk times every panel output except backlight_on and sync_select, which mclk times.
// Notes: Helper counters track sync, valid and line runs.
`timescale 1ns/10ps
module lcd_timing_checker (
  input wire logic mclk,
  input wire logic rst_b,
  input wire lcd_timing_pkg::apb_req_type apb_req,
  input wire lcd_timing_pkg::apb_rsp_type apb_rsp,
  input wire logic pix_clk,
  input wire logic pixel_valid,
  input wire logic hsync_in_b,
  input wire logic vsync_in_b,
  input wire lcd_timing_pkg::rgb_type pixel_rgb,
  input wire logic backlight_on,
  input wire logic sync_select
);
  import lcd_timing_pkg::*;
  logic hs_q, vs_q, started_q, vact_q, hfall, vfall;
  logic [10:0] hcnt_q, vrun_q;
  logic [5:0] hlow_q;
  logic [9:0] vline_q, vlow_q;
  assign hfall = hs_q && !hsync_in_b;
  assign vfall = vs_q && !vsync_in_b;
  // Line length and run counters; idle saturation drops the line check
  always_ff @(posedge pix_clk) begin
    if (!rst_b) begin
      hs_q <= 1'b1;
      hcnt_q <= 11'h7ff;
      started_q <= 1'b0;
      hlow_q <= 6'h0;
      vrun_q <= 11'h0;
    end else begin
      hs_q <= hsync_in_b;
      hcnt_q <= hfall ? 11'h0 : hcnt_q + {10'h0, hcnt_q != 11'h7ff};
      started_q <= hfall | (started_q & (hcnt_q != 11'h7ff));
      hlow_q <= hsync_in_b ? 6'h0 : hlow_q + {5'h0, hlow_q != 6'h3f};
      vrun_q <= pixel_valid ? vrun_q + 11'h1 : 11'h0;
    end
  end
  // Line index within the frame and vertical sync width
  always_ff @(posedge pix_clk) begin
    if (!rst_b) begin
      vs_q <= 1'b1;
      vline_q <= 10'h0;
      vlow_q <= 10'h0;
      vact_q <= 1'b0;
    end else begin
      vs_q <= vsync_in_b;
      if (vfall) begin
        vline_q <= 10'h0;
      end else if (hfall) begin
        vline_q <= vline_q + 10'h1;
      end
      vlow_q <= vsync_in_b ? 10'h0 : vlow_q + {9'h0, hfall};
      vact_q <= !vfall & (vact_q | pixel_valid);
    end
  end
  a_rgb_blank_zero: assert property (@(posedge pix_clk) disable iff (!rst_b)
    !pixel_valid |-> pixel_rgb == '0) else $error("rgb not zero outside valid");
  a_hsync_width: assert property (@(posedge pix_clk) disable iff (!rst_b)
    !hsync_in_b |-> hlow_q < 6'd40) else $error("hsync low too long");
  a_active_count: assert property (@(posedge pix_clk) disable iff (!rst_b)
    $fell(pixel_valid) |-> vrun_q == 11'd800) else $error("active run not 800");
  a_hblank_fixed: assert property (@(posedge pix_clk) disable iff (!rst_b)
    $rose(pixel_valid) |-> $past(hsync_in_b, 46) == 1'b0 && $past(hsync_in_b, 47) == 1'b1)
    else $error("valid not 46 clocks after hsync start");
  a_line_period: assert property (@(posedge pix_clk) disable iff (!rst_b)
    hfall && started_q |-> hcnt_q >= 11'd861 && hcnt_q <= 11'd1199)
    else $error("line period out of range");
  a_vsync_width: assert property (@(posedge pix_clk) disable iff (!rst_b)
    hfall && !vsync_in_b |-> vlow_q < 10'd20) else $error("vsync low too long");
  a_vblank_fixed: assert property (@(posedge pix_clk) disable iff (!rst_b)
    $rose(pixel_valid) && !vact_q |-> vline_q == 10'd23) else $error("first line not 23");
  a_valid_lines: assert property (@(posedge pix_clk) disable iff (!rst_b)
    pixel_valid |-> vline_q >= 10'd23 && vline_q <= 10'd502) else $error("valid in blank line");
  a_apb_answer: assert property (@(posedge mclk) disable iff (!rst_b)
    apb_req.psel && apb_req.penable && !$past(apb_req.penable) |-> ##1 apb_rsp.pready)
    else $error("pready not in second access cycle");
  a_reset_levels: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(rst_b) |-> !backlight_on && !sync_select) else $error("panel controls not off");
endmodule
bind lcd_panel_timing lcd_timing_checker chk_i (.mclk(mclk), .rst_b(rst_b),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .pix_clk(pix_clk), .pixel_valid(pixel_valid),
  .hsync_in_b(hsync_in_b), .vsync_in_b(vsync_in_b), .pixel_rgb(pixel_rgb),
  .backlight_on(backlight_on), .sync_select(sync_select));

// File: verification/panel_model.sv
// Purpose: Panel model measuring syncs, blanking and pixel runs.
// Assumes: Inputs sampled on the forwarded pixel clock.
// Notes: One record per frame start and per active line.
`timescale 1ns/10ps
module panel_model (
  input wire logic pixel_clock,
  input wire logic pixel_valid,
  input wire logic hsync_in_b,
  input wire logic vsync_in_b,
  input wire lcd_timing_pkg::rgb_type pixel_rgb,
  input wire logic backlight_on,
  input wire logic sync_select,
  output logic rec_stb = 1'b0,
  output logic [63:0] rec = 64'h0
);
  import lcd_timing_pkg::*;
  logic hs_q = 1'b1, vs_q = 1'b1, vdone_q = 1'b1, bad_q = 1'b0;
  logic [10:0] hcnt_q = 11'h0;
  logic [6:0] hlow_q = 7'h0, blank_q = 7'h0;
  logic [9:0] act_q = 10'h0, vline_q = 10'h0, vlow_q = 10'h0;
  rgb_type rgb0_q = '0;
  always @(posedge pixel_clock) begin
    hs_q <= hsync_in_b;
    vs_q <= vsync_in_b;
    rec_stb <= 1'b0;
    hcnt_q <= hcnt_q + 11'h1;
    if (!hsync_in_b) begin
      hlow_q <= hlow_q + 7'h1;
    end
    if (pixel_valid) begin
      act_q <= act_q + 10'h1;
      if (act_q == 10'h0) begin
        rgb0_q <= pixel_rgb;
        blank_q <= hcnt_q[6:0] + 7'h1;
      end else if (pixel_rgb != rgb0_q) begin
        bad_q <= 1'b1;
      end
      if (!vdone_q) begin
        vdone_q <= 1'b1;
        rec_stb <= 1'b1;
        rec <= {1'b1, 41'h0, backlight_on, sync_select, vlow_q, vline_q};
      end
    end else if (pixel_rgb != 24'h0) begin
      bad_q <= 1'b1;
    end
    if (hs_q && !hsync_in_b) begin
      hcnt_q <= 11'h0;
      hlow_q <= 7'h1;
      act_q <= 10'h0;
      bad_q <= 1'b0;
      vline_q <= vline_q + 10'h1;
      vlow_q <= vlow_q + {9'h0, !vsync_in_b};
      // Skip a line cut short by reset
      if (act_q != 10'h0 && vdone_q && (vsync_in_b || !vs_q)) begin
        rec_stb <= 1'b1;
        rec <= {5'h0, bad_q, rgb0_q, hcnt_q + 11'h1, hlow_q[5:0], blank_q, act_q};
      end
    end
    if (vs_q && !vsync_in_b) begin
      vline_q <= 10'h0;
      vlow_q <= 10'h1;
      vdone_q <= 1'b0;
    end
  end
endmodule

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the panel timing controller.
// Assumes: Pixel clock 30 ns, control clock 40 ns, unrelated phases.
// Notes: Frames are long, so each run checks frame start and three lines.
`timescale 1ns/10ps
module tb_top;
  import lcd_timing_pkg::*;
  logic mclk = 1'b0;
  logic pix_clk = 1'b0;
  logic rst_b = 1'b0;
  logic listen = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  logic pixel_clock, pixel_valid, hsync_in_b, vsync_in_b, backlight_on, sync_select, rec_stb;
  rgb_type pixel_rgb;
  logic [63:0] rec;
  logic [33:0] e;
  logic [33:0] q_apb[$];
  logic [63:0] q_line[$];
  int failures = 0;
  int n_tests = 0;
  initial begin
    forever #20 mclk = ~mclk;
  end
  initial begin
    #7;
    forever #15 pix_clk = ~pix_clk;
  end
  lcd_panel_timing uut (.mclk(mclk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .pix_clk(pix_clk), .pixel_clock(pixel_clock), .pixel_valid(pixel_valid),
    .hsync_in_b(hsync_in_b), .vsync_in_b(vsync_in_b), .pixel_rgb(pixel_rgb),
    .backlight_on(backlight_on), .sync_select(sync_select));
  panel_model panel (.pixel_clock(pixel_clock), .pixel_valid(pixel_valid),
    .hsync_in_b(hsync_in_b), .vsync_in_b(vsync_in_b), .pixel_rgb(pixel_rgb),
    .backlight_on(backlight_on), .sync_select(sync_select), .rec_stb(rec_stb), .rec(rec));
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Note {check data, error, data} then run one transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] x);
    int i;
    q_apb.push_back(x);
    @(posedge mclk);
    apb_req <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (apb_rsp.pready !== 1'b1 && i < 50);
    apb_req <= '0;
    if (i >= 50) failures++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask
  always @(posedge mclk) begin
    if (apb_rsp.pready === 1'b1) begin
      e = q_apb.pop_front();
      check("pslverr", {63'h0, e[32]}, {63'h0, apb_rsp.pslverr});
      if (e[33]) check("prdata", {32'h0, e[31:0]}, {32'h0, apb_rsp.prdata});
    end
  end
  always @(posedge pixel_clock) begin
    if (rec_stb === 1'b1 && listen && q_line.size() > 0) begin
      check("panel record", q_line.pop_front(), rec);
    end
  end
  task automatic run(input int hpw, input int hfp, input int vpw, input logic sel,
                     input logic inv);
    rgb_type c;
    rgb_type px;
    int i;
    c = 24'($urandom);
    px = inv ? ~c : c;
    wr(OFS_HTIME, 32'((hfp << HFP_POS) | hpw));
    wr(OFS_VTIME, 32'((7 << VFP_POS) | vpw));
    wr(OFS_COLOUR, {8'h0, c});
    q_line.push_back({1'b1, 41'h0, 1'b1, sel, 10'(vpw), 10'd23});
    repeat (3) q_line.push_back({6'h0, px, 11'(846 + hfp), 6'(hpw), 7'd46, 10'd800});
    listen = 1'b1;
    wr(OFS_CTRL, {26'h0, inv, inv, 1'b0, sel, 2'b11});
    i = 0;
    while (q_line.size() > 0 && i < 40000) begin
      @(posedge mclk);
      i++;
    end
    if (i >= 40000) failures++;
    listen = 1'b0;
    rd(OFS_STATUS, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0);
    @(posedge mclk);
    check("ctrl off", 64'h0, {62'h0, backlight_on, sync_select});
    // Disable waits for a frame end, far too long here, so stop by reset
    rst_b <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    check("idle", 64'h6, {59'h0, backlight_on, sync_select, hsync_in_b, vsync_in_b,
      pixel_valid});
    check("idle rgb", 64'h0, {40'h0, pixel_rgb});
    $display("test run %0d %0d done", hpw, hfp);
  endtask
  initial begin
    void'($urandom(71192));
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_HTIME, 32'h00d2_000a);
    rd(OFS_VTIME, 32'h0016_0003);
    rd(OFS_COLOUR, 32'h0);
    apb(1'b0, 8'h14, 32'h0, {2'b01, 32'h0});
    apb(1'b1, 8'h06, 32'h0, {2'b01, 32'h0});
    check("reset levels", 64'h6, {59'h0, backlight_on, sync_select, hsync_in_b, vsync_in_b,
      pixel_valid});
    $display("test reset done");
    wr(OFS_HTIME, 32'h01ff_003f);
    rd(OFS_HTIME, 32'h0162_0028);
    wr(OFS_VTIME, 32'h00ff_0000);
    rd(OFS_VTIME, 32'h0093_0001);
    wr(OFS_STATUS, 32'hffff_ffff);
    $display("test clamp done");
    run(1 + $urandom % 40, 16, 1, 1'b1, 1'b0);
    run(40, 354, 20, 1'b0, 1'b1);
    final_report();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule
